// ---- adapter_ctrl_status.sv ----
// Control register, status register and init sequencing of the adapter.
`timescale 1ns/1ps
`default_nettype none
module adapter_ctrl_status
#(
	parameter int INIT_COUNT = adapter_regs_pkg::INIT_CYCLES,
	parameter int PF_COUNT = adapter_regs_pkg::PF_CYCLES
)
(
	// Clock and resets
	input wire logic i_ref_clk,
	input wire logic i_srst,
	input wire logic i_backplane_a,
	input wire logic i_bus_dead,
	// Register access
	input wire adapter_regs_pkg::reg_req_t i_req,
	output adapter_regs_pkg::reg_rsp_t o_rsp,
	// Jumpers and address space decode
	input wire logic i_space_select_high,
	input wire logic i_space_select_low,
	input wire logic i_addr_valid,
	input wire logic [27:0] i_long_addr,
	output logic [7:0] o_adapter_code,
	output logic o_space_hit,
	// DMA map gating
	input wire logic i_dma_req,
	input wire logic [8:0] i_dma_map_idx,
	output logic o_dma_accept,
	output logic o_dma_ignored,
	// Status events
	input wire logic [10:0] i_err_set,
	input wire logic [3:0] i_vec_loaded,
	input wire logic [3:0] i_vec_read_done,
	input wire logic [4:0] i_env_status,
	// Interrupts
	input wire logic i_periph_irq,
	output logic o_periph_irq_fwd,
	output logic o_periph_irq_internal,
	output logic o_dma_err_irq,
	output logic o_xfer_err_irq,
	output logic o_env_irq,
	// Peripheral bus power fail and adapter reset
	output logic o_ac_power_low,
	output logic o_dc_power_low,
	output logic o_bus_init,
	output logic o_adapter_reset,
	output logic o_init_busy
);
	import adapter_regs_pkg::*;

	logic [CTL_MAPDIS_W-1:0] map_disable_field_r;
	logic interrupt_field_switch_r;
	logic bus_request_irq_enable_r;
	logic dma_error_irq_enable_r;
	logic host_xfer_error_irq_enable_r;
	logic environment_irq_enable_r;
	logic periph_bus_power_fail_r;
	logic [STS_VEC_W-1:0] vec_full_r;
	logic [STS_ERR_W-1:0] err_r;
	logic [1:0] space_sel_r;
	init_state_t state_r;
	init_state_t state_nxt;
	logic init_busy;
	logic pf_busy;
	logic upf_d_r;
	logic init_start;
	logic pf_start;
	logic wr_ctl;
	logic wr_sts;
	logic rd_ctl;
	logic rd_sts;
	logic rd_ok;
	logic wr_ok;
	logic [31:0] ctl_word;
	logic [31:0] sts_word;

	// ==========================================================
	// Access decode
	// Writes are taken as whole longwords; narrower reads still answer.
	always_comb
	begin
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		if (i_req.addr == OFS_CONFIG || i_req.addr == OFS_DIAG)
		begin
			rd_ok = 1'b1; // [RL17]
			wr_ok = 1'b1;
		end
		else if (i_req.addr == OFS_CONTROL)
		begin
			// The refusal window follows the sequence state, so it ends
			// on the same edge as o_init_busy and software sees no gap.
			rd_ok = state_r != ST_INIT; // [RL17] [RL18]
			wr_ok = 1'b1;
		end
		else
		begin
			rd_ok = state_r != ST_INIT; // [RL18]
			wr_ok = state_r != ST_INIT;
		end
	end

	assign wr_ctl = i_req.wr && i_req.addr == OFS_CONTROL; // [RL22]
	assign wr_sts = i_req.wr && i_req.addr == OFS_STATUS && wr_ok;
	assign rd_ctl = i_req.rd && i_req.addr == OFS_CONTROL && rd_ok;
	assign rd_sts = i_req.rd && i_req.addr == OFS_STATUS && rd_ok;
	assign init_start = wr_ctl && i_req.wdata[CTL_INIT]; // [RL4]
	assign pf_start = init_start || (periph_bus_power_fail_r && !upf_d_r);

	// ==========================================================
	// Init and power-fail timers
	interval_timer #(
		.COUNT(INIT_COUNT),
		.WIDTH(TIMER_W)
	) u_init_timer (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_start(init_start),
		.o_busy(init_busy)
	); // [RL16]

	interval_timer #(
		.COUNT(PF_COUNT),
		.WIDTH(TIMER_W)
	) u_pf_timer (
		.i_ref_clk(i_ref_clk),
		.i_srst(i_srst),
		.i_start(pf_start),
		.o_busy(pf_busy)
	); // [RL15] [RL16]

	// ==========================================================
	// Init sequence state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_READY:
			begin
				if (init_start)
				begin
					state_nxt = ST_INIT;
				end
			end
			ST_INIT:
			begin
				if (!init_start && !init_busy)
				begin
					state_nxt = ST_READY;
				end
			end
			default:
			begin
				state_nxt = ST_READY;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			state_r <= ST_READY;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Control register
	// Init wins over a simultaneous write: it clears every field.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			map_disable_field_r <= '0; // [RL7]
			interrupt_field_switch_r <= 1'b0; // [RL9]
			bus_request_irq_enable_r <= 1'b0; // [RL10]
			dma_error_irq_enable_r <= 1'b0; // [RL11]
			host_xfer_error_irq_enable_r <= 1'b0; // [RL12]
			environment_irq_enable_r <= 1'b1; // [RL13]
			periph_bus_power_fail_r <= 1'b0;
		end
		else if (init_start)
		begin
			map_disable_field_r <= '0; // [RL15]
			interrupt_field_switch_r <= 1'b0; // [RL9]
			bus_request_irq_enable_r <= 1'b0; // [RL10]
			dma_error_irq_enable_r <= 1'b0; // [RL11]
			host_xfer_error_irq_enable_r <= 1'b0; // [RL12]
			environment_irq_enable_r <= 1'b0; // [RL13]
			periph_bus_power_fail_r <= 1'b0;
		end
		else
		begin
			if (wr_ctl)
			begin
				map_disable_field_r <= i_req.wdata[CTL_MAPDIS_LSB +:
					CTL_MAPDIS_W]; // [RL3] [RL5]
				interrupt_field_switch_r <= i_req.wdata[CTL_IFS]; // [RL3]
				bus_request_irq_enable_r <= i_req.wdata[CTL_BUS_REQUEST_IRQ_ENABLE];
				dma_error_irq_enable_r <= i_req.wdata[CTL_DMAIE];
				host_xfer_error_irq_enable_r <= i_req.wdata[CTL_XFERIE];
				environment_irq_enable_r <= i_req.wdata[CTL_ENVIE];
				periph_bus_power_fail_r <= i_req.wdata[CTL_UPF]; // [RL14]
			end
			if (i_bus_dead)
			begin
				interrupt_field_switch_r <= 1'b0; // [RL9]
				bus_request_irq_enable_r <= 1'b0; // [RL10]
				host_xfer_error_irq_enable_r <= 1'b0; // [RL12]
				environment_irq_enable_r <= 1'b0; // [RL13]
			end
			if (i_backplane_a)
			begin
				bus_request_irq_enable_r <= 1'b0; // [RL10]
				dma_error_irq_enable_r <= 1'b0; // [RL11]
				host_xfer_error_irq_enable_r <= 1'b0; // [RL12]
				environment_irq_enable_r <= 1'b0; // [RL13]
			end
		end
	end

	// ==========================================================
	// Status register
	// A hardware set in the same cycle as a clear keeps the bit set.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst || init_start)
		begin
			err_r <= '0; // [RL15]
			vec_full_r <= '0;
		end
		else
		begin
			if (wr_sts)
			begin
				err_r <= (err_r & ~i_req.wdata[STS_ERR_W-1:0]) |
					i_err_set; // [RL19]
			end
			else
			begin
				err_r <= err_r | i_err_set; // [RL19]
			end
			vec_full_r <= (vec_full_r & ~i_vec_read_done) |
				(i_vec_loaded & {STS_VEC_W{interrupt_field_switch_r &&
				bus_request_irq_enable_r}}); // [RL20] [RL23]
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			upf_d_r <= 1'b0;
		end
		else
		begin
			upf_d_r <= periph_bus_power_fail_r;
		end
	end

	// ==========================================================
	// Read data assembly
	always_comb
	begin
		ctl_word = '0; // [RL24]
		ctl_word[CTL_MAPDIS_LSB +: CTL_MAPDIS_W] = map_disable_field_r;
		ctl_word[CTL_IFS] = interrupt_field_switch_r;
		ctl_word[CTL_BUS_REQUEST_IRQ_ENABLE] = bus_request_irq_enable_r;
		ctl_word[CTL_DMAIE] = dma_error_irq_enable_r;
		ctl_word[CTL_XFERIE] = host_xfer_error_irq_enable_r;
		ctl_word[CTL_ENVIE] = environment_irq_enable_r;
		ctl_word[CTL_UPF] = periph_bus_power_fail_r;
		ctl_word[CTL_INIT] = init_busy; // [RL4]
		sts_word = '0; // [RL24]
		sts_word[STS_VEC_LSB +: STS_VEC_W] = vec_full_r; // [RL19]
		sts_word[STS_ERR_W-1:0] = err_r;
	end

	// ==========================================================
	// Register answer, one cycle after the request
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_rsp <= '0;
		end
		else
		begin
			o_rsp.ack <= rd_ctl || rd_sts || wr_ctl || wr_sts;
			o_rsp.refused <= (i_req.rd && !rd_ok) ||
				(i_req.wr && !wr_ok); // [RL17]
			if (rd_ctl)
			begin
				o_rsp.rdata <= ctl_word;
			end
			else if (rd_sts)
			begin
				o_rsp.rdata <= sts_word;
			end
			else
			begin
				o_rsp.rdata <= '0;
			end
		end
	end

	// ==========================================================
	// Jumpers and address space decode
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			space_sel_r <= 2'b00;
			o_adapter_code <= '0;
			o_space_hit <= 1'b0;
		end
		else
		begin
			space_sel_r <= {i_space_select_high, i_space_select_low};
			o_adapter_code <= {ADAPTER_CODE_HI, space_sel_r}; // [RL1]
			o_space_hit <= i_addr_valid &&
				i_long_addr[27:SPACE_TAG_LSB] == SPACE_TAG &&
				i_long_addr[SPACE_TAG_LSB-1:SPACE_SEL_LSB] ==
				space_sel_r; // [RL1] [RL2]
		end
	end

	// ==========================================================
	// DMA map gating
	// Registers below sixteen times the field are disabled.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_dma_accept <= 1'b0;
			o_dma_ignored <= 1'b0;
		end
		else
		begin
			o_dma_accept <= i_dma_req && !init_busy &&
				i_dma_map_idx[MAP_IDX_W-1:MAP_GROUP_LSB] >=
				map_disable_field_r; // [RL5] [RL6]
			o_dma_ignored <= i_dma_req &&
				i_dma_map_idx[MAP_IDX_W-1:MAP_GROUP_LSB] <
				map_disable_field_r; // [RL6]
		end
	end

	// ==========================================================
	// Interrupts and peripheral bus power control
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			o_periph_irq_fwd <= 1'b0;
			o_periph_irq_internal <= 1'b0;
			o_dma_err_irq <= 1'b0;
			o_xfer_err_irq <= 1'b0;
			o_env_irq <= 1'b0;
			o_ac_power_low <= 1'b0;
			o_dc_power_low <= 1'b0;
			o_bus_init <= 1'b0;
			o_adapter_reset <= 1'b0;
			o_init_busy <= 1'b0;
		end
		else
		begin
			o_periph_irq_fwd <= i_periph_irq && interrupt_field_switch_r &&
				bus_request_irq_enable_r; // [RL8]
			o_periph_irq_internal <= i_periph_irq &&
				!interrupt_field_switch_r; // [RL8]
			o_dma_err_irq <= dma_error_irq_enable_r &&
				|(err_r & STS_DMA_ERR_MASK); // [RL11]
			o_xfer_err_irq <= host_xfer_error_irq_enable_r &&
				|(err_r & STS_XFER_ERR_MASK); // [RL12]
			o_env_irq <= environment_irq_enable_r &&
				|i_env_status; // [RL13] [RL21]
			o_ac_power_low <= periph_bus_power_fail_r || pf_busy; // [RL14]
			o_dc_power_low <= periph_bus_power_fail_r || pf_busy;
			o_bus_init <= periph_bus_power_fail_r || pf_busy;
			o_adapter_reset <= init_start || init_busy; // [RL15]
			o_init_busy <= state_nxt == ST_INIT;
		end
	end
endmodule
`default_nettype wire

// ---- adapter_regs_pkg.sv ----
// Constants, field layouts and carrier types of the adapter control/status.
// How it works
// (RL1) Jumper bits select one of four bases
// (RL2) Jumper bits match address bits 16, 17
// (RL3) Control bits write one set, zero clear
// (RL4) Adapter init bit sets, then self-clears
// (RL5) Map-disable field disables maps by sixteens
// (RL6) Disabled-map DMA ignored, register access allowed
// (RL7) Map-disable field resets to zero
// (RL8) Field switch routes peripheral interrupts out
// (RL9) Field switch cleared: power-up, init, dead
// (RL10) Bus-request enable cleared: init, backplane_a, dead
// (RL11) DMA error enable gates seven errors
// (RL12) Transfer error enable gates two timeouts
// (RL13) Environment enable, powers up as one
// (RL14) Power-fail bit holds peripheral bus down
// (RL15) Adapter init clears registers, runs power-fail
// (RL16) Init 500 us, power-fail 25 ms
// (RL17) During init only limited registers reachable
// (RL18) After init all registers reachable again
// (RL19) Status vector bits read-only, errors W1C
// (RL20) Vector-full set on vector load
// (RL21) Environment bits 23,22,18,17,16
// (RL22) Software writes whole longwords only
// (RL23) Vector-full cleared after its read completes
// (RL24) Reserved bits read zero, ignore writes
package adapter_regs_pkg;

	// ==========================================================
	// Register offsets (byte addresses in the adapter space)
	localparam logic [11:0] OFS_CONFIG = 12'h000;
	localparam logic [11:0] OFS_CONTROL = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_DIAG = 12'h00C;

	// ==========================================================
	// Control register layout
	localparam int CTL_MAPDIS_LSB = 26;
	localparam int CTL_MAPDIS_W = 5;
	localparam int CTL_IFS = 6;
	localparam int CTL_BUS_REQUEST_IRQ_ENABLE = 5;
	localparam int CTL_DMAIE = 4;
	localparam int CTL_XFERIE = 3;
	localparam int CTL_ENVIE = 2;
	localparam int CTL_UPF = 1;
	localparam int CTL_INIT = 0;

	// ==========================================================
	// Status register layout
	localparam int STS_VEC_LSB = 24;
	localparam int STS_VEC_W = 4;
	localparam int STS_ERR_W = 11;
	localparam logic [10:0] STS_DMA_ERR_MASK = 11'h6F8;
	localparam logic [10:0] STS_XFER_ERR_MASK = 11'h003;

	// ==========================================================
	// Address space decode, on longword addresses
	localparam int SPACE_SEL_LSB = 16;
	localparam int SPACE_TAG_LSB = 18;
	localparam logic [9:0] SPACE_TAG = 10'h201;
	localparam int MAP_IDX_W = 9;
	localparam int MAP_GROUP_LSB = 4;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_TIME_NS = 500000;
	localparam int PF_TIME_NS = 25000000;
	localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;
	localparam int PF_CYCLES = PF_TIME_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 22;

	// Upper adapter-code bits; value is arbitrary.
	localparam logic [5:0] ADAPTER_CODE_HI = 6'h05;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_READY = 2'b00,
		ST_INIT = 2'b01
	} init_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic ack;
		logic refused;
		logic [31:0] rdata;
	} reg_rsp_t;

endpackage

// ---- interval_timer.sv ----
// One-shot interval timer that stays busy for a set number of cycles.
`timescale 1ns/1ps
`default_nettype none
module interval_timer
#(
	parameter int COUNT = 16,
	parameter int WIDTH = 22
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Control
	input wire logic i_start,
	output logic o_busy
);
	logic [WIDTH-1:0] cnt_r;

	// A start while busy restarts the full interval.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst)
		begin
			cnt_r <= '0;
			o_busy <= 1'b0;
		end
		else if (i_start)
		begin
			cnt_r <= WIDTH'(COUNT - 1);
			o_busy <= 1'b1;
		end
		else if (cnt_r != '0)
		begin
			cnt_r <= cnt_r - 1'b1;
		end
		else
		begin
			o_busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- host_model.sv ----
// Backplane processor model that issues longword register requests.
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	// Clock
	input wire logic i_ref_clk,
	// Register access
	output var adapter_regs_pkg::reg_req_t o_req,
	input wire adapter_regs_pkg::reg_rsp_t i_rsp
);
	import adapter_regs_pkg::*;
	logic ack;
	logic refused;
	logic [31:0] rdata;
	initial
	begin
		o_req = '0;
	end
	// ==========
	// Transfer.
	task automatic xfer(input logic r, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge i_ref_clk);
		o_req <= '{rd: r, wr: !r, addr: a, wdata: d};
		@(posedge i_ref_clk);
		// Released lines carry the inverse, so a stale value cannot pass.
		o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
		@(posedge i_ref_clk);
		ack = i_rsp.ack;
		refused = i_rsp.refused;
		rdata = i_rsp.rdata;
	endtask
endmodule
`default_nettype wire

// ---- ctrl_status_chk.sv ----
// Concurrent checks of the adapter control and status block.
`timescale 1ns/1ps
`default_nettype none
module ctrl_status_chk
#(
	parameter int INIT_COUNT = 20
)
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Watched ports
	input wire adapter_regs_pkg::reg_req_t i_req,
	input wire adapter_regs_pkg::reg_rsp_t o_rsp,
	input wire logic i_space_select_high,
	input wire logic i_space_select_low,
	input wire logic [7:0] o_adapter_code,
	input wire logic i_dma_req,
	input wire logic o_dma_accept,
	input wire logic o_dma_ignored,
	input wire logic i_periph_irq,
	input wire logic o_periph_irq_fwd,
	input wire logic o_periph_irq_internal,
	input wire logic o_ac_power_low,
	input wire logic o_dc_power_low,
	input wire logic o_bus_init,
	input wire logic o_adapter_reset,
	input wire logic o_init_busy
);
	import adapter_regs_pkg::*;
	logic [15:0] busy_cnt_r;
	logic [1:0] jmp;
	logic hit;
	logic ctl_wr;
	assign jmp = {i_space_select_high, i_space_select_low};
	assign hit = i_req.addr == OFS_CONTROL || i_req.addr == OFS_STATUS;
	assign ctl_wr = i_req.wr && i_req.addr == OFS_CONTROL && !o_init_busy;
	// ==========
	// Init length.
	// A counter bounds the init time; a repetition that long stalls tools.
	always_ff @(posedge i_ref_clk)
	begin
		if (i_srst || !o_init_busy)
			busy_cnt_r <= 16'h0;
		else
			busy_cnt_r <= busy_cnt_r + 16'h1;
	end
	// ==========
	// Assertions.
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_srst);
	reg_answer_a: assert property (
		(i_req.rd || i_req.wr) && hit && !o_init_busy
		|=> o_rsp.ack && !o_rsp.refused)
		else $error("Register access not acknowledged.");
	init_refuse_a: assert property (
		o_init_busy && i_req.rd && i_req.addr == OFS_STATUS
		|=> o_rsp.refused && !o_rsp.ack)
		else $error("Status read during init not refused.");
	init_start_a: assert property (
		ctl_wr && i_req.wdata[CTL_INIT] |=> o_init_busy && o_adapter_reset)
		else $error("Init write did not start init.");
	init_length_a: assert property (
		$fell(o_init_busy) |-> busy_cnt_r >= INIT_COUNT - 1
		&& busy_cnt_r <= INIT_COUNT + 1)
		else $error("Init length wrong.");
	init_pf_a: assert property (
		$rose(o_adapter_reset) |-> ##[0:2] o_ac_power_low)
		else $error("Init did not start power fail.");
	pf_lines_a: assert property (
		o_dc_power_low == o_ac_power_low && o_bus_init == o_ac_power_low)
		else $error("Power fail lines disagree.");
	pf_start_a: assert property (
		ctl_wr && i_req.wdata[CTL_UPF] && !i_req.wdata[CTL_INIT]
		|-> ##[1:2] o_ac_power_low)
		else $error("Power fail bit did not assert lines.");
	dma_answer_a: assert property (
		i_dma_req |=> o_dma_accept != o_dma_ignored)
		else $error("DMA request not answered once.");
	irq_route_a: assert property (
		o_periph_irq_fwd |-> !o_periph_irq_internal && $past(i_periph_irq))
		else $error("Peripheral interrupt misrouted.");
	code_jumper_a: assert property (
		(!i_srst && $stable(jmp)) [*3] |-> o_adapter_code[1:0] == jmp)
		else $error("Adapter code does not follow jumpers.");
	cover property ($rose(o_init_busy));
	cover property (o_rsp.refused);
	cover property (o_dma_ignored);
	cover property (o_periph_irq_fwd);
endmodule
bind adapter_ctrl_status ctrl_status_chk #(.INIT_COUNT(INIT_COUNT)) chk (
	.i_ref_clk, .i_srst, .i_req, .o_rsp, .i_space_select_high,
	.i_space_select_low, .o_adapter_code, .i_dma_req, .o_dma_accept,
	.o_dma_ignored, .i_periph_irq, .o_periph_irq_fwd,
	.o_periph_irq_internal, .o_ac_power_low, .o_dc_power_low, .o_bus_init,
	.o_adapter_reset, .o_init_busy
);
`default_nettype wire

// ---- tb_peripheral_bus_adapter_ctrl_status.sv ----
// Self-checking bench of the adapter control and status block.
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_bus_adapter_ctrl_status;
	import adapter_regs_pkg::*;
	localparam int INIT_N = 20;
	localparam int PF_N = 50;
	typedef struct packed {logic [31:0] wd; logic [31:0] exp;} row_t;
	logic i_ref_clk = 1'b0;
	logic i_srst, i_backplane_a, i_bus_dead, i_addr_valid, i_dma_req;
	logic i_space_select_high, i_space_select_low, i_periph_irq;
	logic [27:0] i_long_addr;
	logic [8:0] i_dma_map_idx;
	logic [10:0] i_err_set;
	logic [3:0] i_vec_loaded, i_vec_read_done;
	logic [4:0] i_env_status;
	logic [7:0] o_adapter_code;
	logic o_space_hit, o_dma_accept, o_dma_ignored, o_periph_irq_fwd;
	logic o_periph_irq_internal, o_dma_err_irq, o_xfer_err_irq, o_env_irq;
	logic o_ac_power_low, o_dc_power_low, o_bus_init, o_adapter_reset;
	logic o_init_busy;
	reg_req_t i_req;
	reg_rsp_t o_rsp;
	int errors = 0;
	int compares = 0;
	int n;
	row_t rows [4] = '{'{32'hFFFFFFFE, 32'h7C00007E}, '{32'h0, 32'h0},
		'{32'h84000060, 32'h04000060}, '{32'h2C, 32'h2C}};
	always #5 i_ref_clk = ~i_ref_clk;
	adapter_ctrl_status #(.INIT_COUNT(INIT_N), .PF_COUNT(PF_N)) DUT (
		.i_ref_clk, .i_srst, .i_backplane_a, .i_bus_dead, .i_req, .o_rsp,
		.i_space_select_high, .i_space_select_low, .i_addr_valid,
		.i_long_addr, .o_adapter_code, .o_space_hit, .i_dma_req,
		.i_dma_map_idx, .o_dma_accept, .o_dma_ignored, .i_err_set,
		.i_vec_loaded, .i_vec_read_done, .i_env_status, .i_periph_irq,
		.o_periph_irq_fwd, .o_periph_irq_internal, .o_dma_err_irq,
		.o_xfer_err_irq, .o_env_irq, .o_ac_power_low, .o_dc_power_low,
		.o_bus_init, .o_adapter_reset, .o_init_busy);
	host_model host (.i_ref_clk, .o_req(i_req), .i_rsp(o_rsp));
	// ==========
	// Tasks.
	task automatic report_and_stop();
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk_reg(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		chk_reg(what, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge i_ref_clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		host.xfer(1'b0, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		host.xfer(1'b1, a, 32'h0);
	endtask
	// A hung wait counts as a mismatch and ends the run.
	task automatic wait_clear(input bit pf, input int lim);
		n = 0;
		while ((pf ? o_ac_power_low : o_init_busy) !== 1'b0)
		begin
			if (n == lim)
			begin
				errors++;
				report_and_stop();
			end
			n++;
			@(posedge i_ref_clk);
		end
	endtask
	function automatic logic [27:0] base(input int j);
		return 28'((32'h20100000 + 32'h40000 * (j % 4)) >> 2);
	endfunction
	// ==========
	// Sequence.
	initial
	begin
		i_srst = 1'b1;
		{i_backplane_a, i_bus_dead, i_addr_valid, i_dma_req} = 4'h0;
		{i_space_select_high, i_space_select_low, i_periph_irq} = 3'h0;
		{i_long_addr, i_dma_map_idx, i_err_set} = 48'h0;
		{i_vec_loaded, i_vec_read_done, i_env_status} = 13'h0;
		tick(2);
		i_srst <= 1'b0;
		foreach (rows[i])
		begin
			wr(OFS_CONTROL, rows[i].wd);
			chk_bit("write ack", 1'b1, host.ack);
			rd(OFS_CONTROL);
			chk_reg("control", rows[i].exp, host.rdata);
		end
		// A second reset mid-run must restore the power-up values.
		@(posedge i_ref_clk);
		i_srst <= 1'b1;
		tick(2);
		i_srst <= 1'b0;
		rd(OFS_CONTROL);
		chk_reg("control reset", 32'h4, host.rdata);
		i_periph_irq <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			wr(OFS_CONTROL, k == 0 ? 32'h60 : 32'h40 >> (k - 1));
			tick(2);
			chk_bit("irq fwd", k == 0, o_periph_irq_fwd);
			chk_bit("irq internal", k == 2, o_periph_irq_internal);
		end
		i_periph_irq <= 1'b0;
		wr(OFS_CONTROL, 32'h1C);
		for (int b = 0; b < 11; b++)
		begin
			@(posedge i_ref_clk);
			i_err_set <= 11'h1 << b;
			@(posedge i_ref_clk);
			i_err_set <= 11'h0;
			tick(2);
			chk_bit("dma irq", STS_DMA_ERR_MASK[b], o_dma_err_irq);
			chk_bit("xfer irq", STS_XFER_ERR_MASK[b], o_xfer_err_irq);
			wr(OFS_STATUS, 32'h0);
			rd(OFS_STATUS);
			chk_reg("status hold", 32'h1 << b, host.rdata);
			wr(OFS_STATUS, 32'h1 << b);
			rd(OFS_STATUS);
			chk_reg("status clear", 32'h0, host.rdata);
		end
		i_env_status <= 5'h10;
		tick(2);
		chk_bit("env irq", 1'b1, o_env_irq);
		wr(OFS_CONTROL, 32'h18);
		tick(2);
		chk_bit("env irq off", 1'b0, o_env_irq);
		i_env_status <= 5'h0;
		for (int k = 0; k < 2; k++)
		begin
			wr(OFS_CONTROL, 32'h7E);
			@(posedge i_ref_clk);
			{i_bus_dead, i_backplane_a} <= k == 0 ? 2'h1 : 2'h2;
			@(posedge i_ref_clk);
			{i_bus_dead, i_backplane_a} <= 2'h0;
			rd(OFS_CONTROL);
			chk_reg("cleared", k == 0 ? 32'h42 : 32'h12, host.rdata);
		end
		wr(OFS_CONTROL, 32'h0);
		wait_clear(1'b1, PF_N + 10);
		wr(OFS_CONTROL, 32'h2);
		tick(PF_N + 5);
		chk_bit("bus held down", 1'b1, o_ac_power_low);
		wr(OFS_CONTROL, 32'h0);
		wait_clear(1'b1, 10);
		for (int k = 0; k < 2; k++)
		begin
			wr(OFS_CONTROL, k == 0 ? 32'h0 : 32'h60);
			@(posedge i_ref_clk);
			i_vec_loaded <= 4'h2;
			@(posedge i_ref_clk);
			i_vec_loaded <= 4'h0;
			wr(OFS_STATUS, 32'h02000000);
			rd(OFS_STATUS);
			chk_reg("vector full", k == 0 ? 32'h0 : 32'h02000000, host.rdata);
		end
		i_vec_read_done <= 4'h2;
		@(posedge i_ref_clk);
		i_vec_read_done <= 4'h0;
		rd(OFS_STATUS);
		chk_reg("vector read", 32'h0, host.rdata);
		wr(OFS_CONTROL, 32'h08000000);
		for (int k = 0; k < 2; k++)
		begin
			@(posedge i_ref_clk);
			i_dma_req <= 1'b1;
			i_dma_map_idx <= 9'(31 + k);
			@(posedge i_ref_clk);
			i_dma_req <= 1'b0;
			@(posedge i_ref_clk);
			chk_bit("dma accept", k == 1, o_dma_accept);
			chk_bit("dma ignored", k == 0, o_dma_ignored);
		end
		rd(OFS_STATUS);
		chk_reg("no dma error", 32'h0, host.rdata);
		i_addr_valid <= 1'b1;
		for (int j = 0; j < 4; j++)
		begin
			@(posedge i_ref_clk);
			{i_space_select_high, i_space_select_low} <= 2'(j);
			i_long_addr <= base(j);
			tick(3);
			chk_reg("code", 32'(j), 32'(o_adapter_code[1:0]));
			chk_bit("space hit", 1'b1, o_space_hit);
			i_long_addr <= base(j + 1);
			tick(3);
			chk_bit("space miss", 1'b0, o_space_hit);
		end
		i_err_set <= 11'h008;
		@(posedge i_ref_clk);
		i_err_set <= 11'h0;
		wr(OFS_CONTROL, 32'h7E);
		wr(OFS_CONTROL, 32'h1);
		chk_bit("init ack", 1'b1, host.ack);
		rd(OFS_CONTROL);
		chk_bit("init ctl refused", 1'b1, host.refused);
		rd(OFS_STATUS);
		chk_bit("init sts refused", 1'b1, host.refused);
		rd(OFS_CONFIG);
		chk_bit("init cfg refused", 1'b0, host.refused);
		wait_clear(1'b0, INIT_N + 10);
		chk_bit("bus fail after init", 1'b1, o_ac_power_low);
		rd(OFS_CONTROL);
		chk_reg("control after init", 32'h0, host.rdata);
		rd(OFS_STATUS);
		chk_reg("status after init", 32'h0, host.rdata);
		report_and_stop();
	end
endmodule
`default_nettype wire
